// ===== verilog/sar_pkg.sv
/*
  Shared constants for the successive-approximation sequencer and its
  comparison-level generator: widths, timing counts, interrupt vector data.
  Assumes the system clock stands in for the main clock input.
*/
package sar_pkg;

  // Result and comparison-level widths
  localparam int          RES_W          = 10;
  localparam int          LVL_W          = 11;

  // Top bit index and trial count per mode
  localparam logic [3:0]  TOP_BIT_10     = 4'h9;
  localparam logic [3:0]  TOP_BIT_8      = 4'h7;
  localparam logic [3:0]  TRIALS_10      = 4'ha;
  localparam logic [3:0]  TRIALS_8       = 4'h8;

  // One conversion-clock cycle is this many main-clock periods
  localparam int          CONV_CLK_DIV   = 2;
  localparam int          CONV_CYC_10    = 61;
  localparam int          CONV_CYC_8     = 50;

  // Completion points in system clocks after the start edge
  localparam logic [7:0]  DONE_SYS_10    = 8'(CONV_CYC_10 * CONV_CLK_DIV);
  localparam logic [7:0]  DONE_SYS_8     = 8'(CONV_CYC_8 * CONV_CLK_DIV);

  // System clocks per trial (fits both budgets)
  localparam logic [3:0]  STEP_SYS       = 4'hc;

  // Least main clock during a conversion, in kHz (held by clock control)
  localparam int          MIN_MAIN_KHZ   = 500;

  // Interrupt identity of the completion event
  localparam logic [4:0]  IRQ_PRIORITY   = 5'h10;
  localparam logic [15:0] IRQ_VEC_HIGH   = 16'hffdf;
  localparam logic [15:0] IRQ_VEC_LOW    = 16'hffde;

  // Reset values
  localparam logic [9:0]  RESULT_RST     = 10'h000;
  localparam logic [10:0] LEVEL_RST      = 11'h000;

  // Sequencer states, Gray order along the usual path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLEAR = 2'b01,
    ST_TRIAL = 2'b11,
    ST_HOLD  = 2'b10
  } seq_state_t;

endpackage

// ===== verilog/sar_ladder.sv
/*
  Comparison-level generator: turns the trial code into the level that the
  comparator sees, in units of one 2048th of the reference.
  Assumes the code is stable for a full trial step.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_ladder
  import sar_pkg::*;
(
  input  wire logic               i_clk,     // System clock
  input  wire logic               i_reset,   // Synchronous reset
  input  wire logic               i_mode8,   // 8-bit mode
  input  wire logic [RES_W-1:0]   i_code,    // Trial code
  output logic      [LVL_W-1:0]   o_level    // Level, ref/2048 units
);

  logic [LVL_W-1:0] level_next;

  // Code to level, code zero always gives zero
  always_comb begin
    level_next = LEVEL_RST;
    if (i_code != RESULT_RST) begin
      if (i_mode8) begin
        level_next = {i_code[7:0], 3'b000} - 11'h004;
      end else begin
        level_next = {i_code, 1'b0};
      end
    end
  end

  // Registered level output
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= LEVEL_RST;
    end else begin
      o_level <= level_next;
    end
  end

  // Level checks one cycle after the code
  ten_bit_level_a : assert property (@(posedge i_clk) disable iff (i_reset)
    !i_mode8 ##1 !$past(i_reset) |->
      o_level == {$past(i_code), 1'b0})
    else $error("ten-bit level wrong");

  eight_bit_level_a : assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode8 && i_code != 10'h000) |=>
      o_level == 11'(({3'b000, $past(i_code[7:0])} << 3) - 11'h004))
    else $error("eight-bit level wrong");

endmodule

`default_nettype wire

// ===== verilog/sar_adc_sequencer.sv
/*
  Successive-approximation sequencer: starts on a clear of the completion
  flag, resolves one bit per trial from the top down, stores the result and
  raises completion and interrupt flags at a fixed time.
  Assumes the comparator answer is synchronous to I_SYS_CLK and the clock
  stands in for the main clock input.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Clearing completion flag starts a conversion
// - Result cleared to zero at start
// - First trial sets top bit, drives level
// - Keep bit if level below input
// - Ten trials or eight trials, top down
// - Ten-bit conversion ends after 61 cycles
// - Eight-bit conversion ends after 50 cycles
// - Final code stays in result register
// - Completion and interrupt flags set together
// - Ten-bit level is n times ref/1024
// - Eight-bit level offset half a step down
// - Interrupt priority 16, fixed vector pair
module sar_adc_sequencer
  import sar_pkg::*;
(
  input  wire logic                       I_SYS_CLK,       // System clock, 100 MHz
  input  wire logic                       I_RESET,         // Sync reset, active high
  input  wire logic                       I_START_WR,      // Pulse: flag written with 0
  input  wire logic                       I_MODE8,         // 1 = 8-bit mode
  input  wire logic                       I_LEVEL_BELOW,   // Level below analog input
  input  wire logic                       I_IRQ_ACK,       // Pulse: clear request flag
  output logic      [sar_pkg::RES_W-1:0]  O_RESULT,        // Conversion result
  output logic      [sar_pkg::LVL_W-1:0]  O_TRIAL_LEVEL,   // Level to comparator
  output logic                            O_DONE_FLAG,     // Completion flag
  output logic                            O_IRQ_FLAG,      // Interrupt request flag
  output logic                            O_BUSY,          // Conversion running
  output logic      [4:0]                 O_IRQ_PRIORITY,  // Fixed priority
  output logic      [15:0]                O_IRQ_VEC_HIGH,  // Vector high address
  output logic      [15:0]                O_IRQ_VEC_LOW    // Vector low address
);

  import sar_pkg::*;

  seq_state_t       state_reg;
  logic [RES_W-1:0] result_reg;
  logic [7:0]       tot_reg;
  logic [3:0]       step_reg;
  logic [3:0]       bit_reg;
  logic [3:0]       trials_reg;
  logic             mode8_reg;
  logic             done_reg;
  logic             irq_reg;
  logic             decide;
  logic             finish;
  logic [7:0]       done_point;

  // Decision and completion points
  assign decide     = (state_reg == ST_TRIAL) && (step_reg == STEP_SYS - 4'h1);
  assign done_point = mode8_reg ? DONE_SYS_8 : DONE_SYS_10;
  assign finish     = (state_reg == ST_HOLD) && (tot_reg == done_point - 8'h01);

  // Sequence state
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state_reg <= ST_IDLE;
    end else if (I_START_WR) begin
      state_reg <= ST_CLEAR;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_CLEAR: begin
          state_reg <= ST_TRIAL;
        end
        ST_TRIAL: begin
          if (decide && bit_reg == 4'h0) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (finish) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Latched mode for the whole conversion
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      mode8_reg <= 1'b0;
    end else if (I_START_WR) begin
      mode8_reg <= I_MODE8;
    end
  end

  // Elapsed system clocks since start
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      tot_reg <= 8'h00;
    end else if (I_START_WR) begin
      tot_reg <= 8'h00;
    end else if (state_reg != ST_IDLE) begin
      tot_reg <= tot_reg + 8'h01;
    end
  end

  // Step counter and bit index
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      step_reg   <= 4'h0;
      bit_reg    <= 4'h0;
      trials_reg <= 4'h0;
    end else if (state_reg == ST_CLEAR && !I_START_WR) begin
      step_reg   <= 4'h0;
      bit_reg    <= mode8_reg ? TOP_BIT_8 : TOP_BIT_10;
      trials_reg <= 4'h1;
    end else if (state_reg == ST_TRIAL && !I_START_WR) begin
      if (decide) begin
        step_reg <= 4'h0;
        if (bit_reg != 4'h0) begin
          bit_reg    <= bit_reg - 4'h1;
          trials_reg <= trials_reg + 4'h1;
        end
      end else begin
        step_reg <= step_reg + 4'h1;
      end
    end
  end

  // Result register: clear, set trial bit, resolve
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      result_reg <= RESULT_RST;
    end else if (I_START_WR) begin
      result_reg <= RESULT_RST;
    end else if (state_reg == ST_CLEAR) begin
      result_reg[mode8_reg ? TOP_BIT_8 : TOP_BIT_10] <= 1'b1;
    end else if (decide) begin
      if (!I_LEVEL_BELOW) begin
        result_reg[bit_reg] <= 1'b0;
      end
      if (bit_reg != 4'h0) begin
        result_reg[bit_reg - 4'h1] <= 1'b1;
      end
    end
  end

  // Completion flag: cleared by start, set at finish
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      done_reg <= 1'b0;
    end else if (I_START_WR) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end
  end

  // Interrupt request flag, set wins over clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      irq_reg <= 1'b0;
    end else if (finish && !I_START_WR) begin
      irq_reg <= 1'b1;
    end else if (I_IRQ_ACK) begin
      irq_reg <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_BUSY         <= 1'b0;
      O_IRQ_PRIORITY <= IRQ_PRIORITY;
      O_IRQ_VEC_HIGH <= IRQ_VEC_HIGH;
      O_IRQ_VEC_LOW  <= IRQ_VEC_LOW;
    end else begin
      O_BUSY         <= I_START_WR || (state_reg != ST_IDLE && !finish);
      O_IRQ_PRIORITY <= IRQ_PRIORITY;
      O_IRQ_VEC_HIGH <= IRQ_VEC_HIGH;
      O_IRQ_VEC_LOW  <= IRQ_VEC_LOW;
    end
  end

  assign O_RESULT    = result_reg;
  assign O_DONE_FLAG = done_reg;
  assign O_IRQ_FLAG  = irq_reg;

  // Comparison-level generator
  sar_ladder u_ladder (
    .i_clk   (I_SYS_CLK),
    .i_reset (I_RESET),
    .i_mode8 (mode8_reg),
    .i_code  (result_reg),
    .o_level (O_TRIAL_LEVEL)
  );

  // Checks on the sequence
  start_clears_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    I_START_WR |=> (result_reg == RESULT_RST) && (state_reg == ST_CLEAR))
    else $error("start did not clear result");

  start_flag_low_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    I_START_WR |=> !done_reg && O_BUSY)
    else $error("start did not begin conversion");

  msb_first_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg == ST_CLEAR && !I_START_WR) |=>
      result_reg == (mode8_reg ? 10'h080 : 10'h200))
    else $error("first trial code wrong");

  keep_bit_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (decide && !I_START_WR) |=>
      result_reg[$past(bit_reg)] == $past(I_LEVEL_BELOW))
    else $error("trial bit not resolved from comparator");

  trial_count_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg == ST_HOLD) |->
      trials_reg == (mode8_reg ? TRIALS_8 : TRIALS_10))
    else $error("wrong number of trials");

  ten_bit_time_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(done_reg) && !mode8_reg |-> $past(tot_reg) == DONE_SYS_10 - 8'h01)
    else $error("ten-bit conversion time wrong");

  eight_bit_time_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(done_reg) && mode8_reg |-> $past(tot_reg) == DONE_SYS_8 - 8'h01)
    else $error("eight-bit conversion time wrong");

  result_hold_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (done_reg && !I_START_WR) |=> $stable(result_reg))
    else $error("result changed after completion");

  flags_together_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(done_reg) |-> irq_reg && !$past(O_DONE_FLAG))
    else $error("interrupt flag missing at completion");

  flag_low_busy_a : assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg != ST_IDLE) |-> !done_reg)
    else $error("completion flag high during conversion");

  // Main scenarios
  ten_bit_done_c : cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(done_reg) && !mode8_reg);
  eight_bit_done_c : cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $rose(done_reg) && mode8_reg);
  restart_c : cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg == ST_TRIAL) && I_START_WR);
  ack_race_c : cover property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    finish && I_IRQ_ACK);

endmodule

`default_nettype wire

// ===== sim/sar_comparator_model.sv
/*
  Comparator model for the sequencer: compares the trial level with a held
  analog input level, promptly or through a short delay line.
  Assumes both levels are in units of one 2048th of the reference.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_comparator_model (
  input  wire logic        i_clk,                 // System clock
  input  wire logic [10:0] i_trial_level,         // Level from the ladder
  input  wire logic [11:0] i_analog_input_level,  // Held input level
  input  wire logic        i_slow,                // 1 = delayed answer
  output logic             o_level_below          // Level below input
);
  logic       now_below;
  logic [3:0] dly_reg;

  // Strict compare, an equal level counts as above
  assign now_below = ({1'b0, i_trial_level} < i_analog_input_level);

  // Slow answer trails by four clocks, still settled before the decision
  always_ff @(posedge i_clk) begin
    dly_reg <= {dly_reg[2:0], now_below};
  end

  // Answer picked by speed
  assign o_level_below = i_slow ? dly_reg[3] : now_below;
endmodule

`default_nettype wire

// ===== sim/test_sar_adc_sequencer.sv
/*
  Self-checking bench for the sequencer: starts conversions in both modes,
  restarts, resets mid-run and acknowledges the request flag.
  Assumes the comparator model of this folder and the design package.
*/
`timescale 1ns/1ps
`default_nettype none

module test_sar_adc_sequencer;
  import sar_pkg::*;

  typedef struct {
    logic [9:0] res;
    int         due;
    int         n;
    logic       m8;
  } expect_t;

  localparam int LIMIT = 20000;

  logic        clk, rst, start, mode8, below, ack, slow, done, irq, busy;
  logic [11:0] ain_level;
  logic [9:0]  result, last_res;
  logic [10:0] level;
  logic [4:0]  prio;
  logic [15:0] vec_hi, vec_lo;
  logic [11:0] bnd[4] = '{12'h000, 12'h001, 12'h7ff, 12'h400};
  int          cyc = 0;
  int          bad_count = 0;
  int          check_count = 0;
  expect_t     q[$];

  // Main clock, far above the least rate a conversion needs
  initial clk = 1'b0;
  always #5 clk = ~clk;

  sar_adc_sequencer dut (
    .I_SYS_CLK(clk), .I_RESET(rst), .I_START_WR(start), .I_MODE8(mode8),
    .I_LEVEL_BELOW(below), .I_IRQ_ACK(ack), .O_RESULT(result),
    .O_TRIAL_LEVEL(level), .O_DONE_FLAG(done), .O_IRQ_FLAG(irq), .O_BUSY(busy),
    .O_IRQ_PRIORITY(prio), .O_IRQ_VEC_HIGH(vec_hi), .O_IRQ_VEC_LOW(vec_lo)
  );

  sar_comparator_model cmp (
    .i_clk(clk), .i_trial_level(level), .i_analog_input_level(ain_level),
    .i_slow(slow), .o_level_below(below)
  );

  // Level of a code in ref/2048 units
  function automatic int lvl(input logic m8, input logic [9:0] c);
    return (c == 10'h0) ? 0 : (m8 ? 8 * c - 4 : 2 * c);
  endfunction

  // Expected code, one trial per bit from the top
  function automatic logic [9:0] sar(input logic m8, input logic [11:0] a);
    logic [9:0] c;
    c = 10'h0;
    for (int i = (m8 ? 7 : 9); i >= 0; i--) begin
      c[i] = 1'b1;
      if (!(lvl(m8, c) < int'(a))) c[i] = 1'b0;
    end
    return c;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One start pulse, expectation noted
  task automatic go(input logic m8, input logic [11:0] a, input logic s);
    expect_t e;
    @(posedge clk);
    start <= 1'b1;
    mode8 <= m8;
    ain_level <= a;
    slow  <= s;
    e.m8  = m8;
    e.n   = m8 ? 100 : 122;
    e.due = cyc + 2 + e.n;
    e.res = sar(m8, a);
    q.delete();
    q.push_back(e);
    @(posedge clk);
    start <= 1'b0;
    mode8 <= ~m8;
  endtask

  task automatic settle();
    for (int k = 0; k < 200 && q.size() > 0; k++) @(posedge clk);
    check(16'(q.size()), 16'h0);
  endtask

  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  // Output watcher, oldest note first
  always @(negedge clk) begin
    if (!rst && q.size() > 0) begin
      if (cyc == q[0].due - q[0].n) begin
        check(16'(result), 16'h0);
        check(16'(busy), 16'h1);
      end
      if (cyc == q[0].due - q[0].n + 1)
        check(16'(result), q[0].m8 ? 16'h080 : 16'h200);
      if (cyc == q[0].due - q[0].n + 2)
        check(16'(level), q[0].m8 ? 16'h3fc : 16'h400);
      if (cyc >= q[0].due - q[0].n && cyc < q[0].due)
        check(16'(done), 16'h0);
      if (cyc == q[0].due) begin
        check(16'(result), 16'(q[0].res));
        check(16'(level), 16'(lvl(q[0].m8, q[0].res)));
        check({13'h0, done, irq, busy}, 16'h6);
        last_res = q[0].res;
        q.delete(0);
      end
    end
  end

  initial begin
    rst = 1'b1; start = 1'b0; mode8 = 1'b0; ack = 1'b0; slow = 1'b0; ain_level = 12'h0;
    void'($urandom(32'h5e87));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({11'h0, prio}, 16'h10);
    check(vec_hi, 16'hffdf);
    check(vec_lo, 16'hffde);
    // Both modes, boundary inputs then random ones
    for (int i = 0; i < 12; i++) begin
      go(i[0], (i < 4) ? bnd[i] : {1'b0, 11'($urandom())}, i[1]);
      settle();
    end
    // Acknowledge clears only the request, result holds
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (20) @(negedge clk);
    check({14'h0, done, irq}, 16'h2);
    check(16'(result), 16'(last_res));
    // Start in the completion cycle wins, no flag is set
    go(1'b1, 12'h1c3, 1'b0);
    repeat (98) @(posedge clk);
    go(1'b0, 12'h2e5, 1'b1);
    @(negedge clk);
    check({14'h0, done, irq}, 16'h0);
    settle();
    // Acknowledge in the completion cycle loses to the set
    go(1'b1, 12'h0f1, 1'b0);
    repeat (99) @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    settle();
    // Restart in mid-conversion with the other mode
    go(1'b0, 12'h155, 1'b0);
    repeat (30) @(posedge clk);
    go(1'b1, 12'h2aa, 1'b1);
    settle();
    // Reset in mid-conversion, then a clean run
    go(1'b0, 12'h3ff, 1'b0);
    repeat (40) @(posedge clk);
    rst <= 1'b1;
    q.delete();
    @(posedge clk);
    @(negedge clk);
    check({result, 3'h0, done, irq, busy}, 16'h0);
    @(posedge clk);
    rst <= 1'b0;
    go(1'b1, {1'b0, 11'($urandom())}, 1'b0);
    settle();
    wrap_up();
  end
endmodule

`default_nettype wire
